// file: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       adr_we = 1'b0, dat_we = 1'b0, dat_re = 1'b0;
  logic [7:0] wdata = 8'h00, rdata, tx_data, rx_data;
  logic       rx_valid, rx_ep, rx_last, rx_err, rx_ready, tx_rd, tx_rewind;
  logic       stall, irq, toggle, rd_d = 1'b0, tx_d = 1'b0, full_seen = 1'b0;
  logic [7:0] rq [$], tq [$], rxq [$];
  int         err_total = 0, checks = 0, irq_n = 0, stl_n = 0, n;

  initial begin
    forever #2.5 clk = ~clk;
  end

  ufm_top #(.STAGE_DEPTH(4)) uut (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_adr_we(adr_we), .i_dat_we(dat_we),
    .i_dat_re(dat_re), .i_wdata(wdata), .o_rdata(rdata), .i_rx_valid(rx_valid),
    .i_rx_ep(rx_ep), .i_rx_last(rx_last), .i_rx_err(rx_err), .i_rx_data(rx_data),
    .o_rx_ready(rx_ready), .i_tx_rd(tx_rd), .i_tx_ep(1'b1), .i_tx_rewind(tx_rewind),
    .o_tx_data(tx_data), .o_stall_hs(stall), .o_out_irq(irq), .o_data_toggle(toggle));

  ufm_host host (
    .i_sys_clk(clk), .o_rx_valid(rx_valid), .o_rx_ep(rx_ep), .o_rx_last(rx_last),
    .o_rx_err(rx_err), .o_rx_data(rx_data), .i_rx_ready(rx_ready), .o_tx_rd(tx_rd),
    .o_tx_rewind(tx_rewind));

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_n(input int g, input int e);
    checks++;
    if (g != e) begin
      err_total++;
      $display("BAD t=%0t count %0d exp %0d", $time, g, e);
    end
  endtask

  // Results are compared in the cycle after the edge that took the request.
  always @(posedge clk) begin
    rd_d <= dat_re;
    tx_d <= tx_rd;
  end
  always @(negedge clk) begin
    if (rd_d) chk8(rdata, rq.pop_front());
    if (tx_d) chk8(tx_data, tq.pop_front());
    irq_n += int'(irq === 1'b1);
    stl_n += int'(stall === 1'b1);
    full_seen |= (rx_ready === 1'b0);
  end

  task automatic adr(input logic [7:0] a);
    {adr_we, wdata} = {1'b1, a};
    @(negedge clk);
    adr_we = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    adr(a);
    {dat_we, wdata} = {1'b1, d};
    @(negedge clk);
    dat_we = 1'b0;
  endtask
  // FIFO data addresses have bit 5 set; their reads expect the bytes sent earlier.
  task automatic rd(input logic [7:0] a, input int k, input logic [7:0] e);
    adr(a);
    repeat (k) begin
      rq.push_back(a[5] ? rxq.pop_front() : e);
      dat_re = 1'b1;
      @(negedge clk);
    end
    dat_re = 1'b0;
  endtask
  task automatic fill(input int k);
    adr(8'h21);
    repeat (k) begin
      {dat_we, wdata} = {1'b1, 8'($urandom)};
      tq.push_back(wdata);
      @(negedge clk);
    end
    dat_we = 1'b0;
  endtask
  task automatic pkt(input logic ep, input logic err, input int k, input bit keep);
    for (int i = 0; i < k; i++) begin
      host.pkt[i] = 8'($urandom);
      if (keep) rxq.push_back(host.pkt[i]);
    end
    host.send(ep, err, k);
    if (host.hang != 0) end_of_test();
  endtask
  task automatic wait_irq(input int k);
    int w = 0;
    while (irq_n < k && w < 40) begin
      @(negedge clk);
      w++;
    end
    chk_n(irq_n, k);
    if (irq_n < k) end_of_test();
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_of_test();
    err_total += host.hang;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'hFCB4));
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    wr(8'h0E, 8'h01);
    rd(8'h14, 1, 8'h00);
    rd(8'h16, 1, 8'h00);
    rd(8'h40, 1, 8'h00);
    note("reset");
    pkt(1'b1, 1'b0, 3, 1'b1);
    wait_irq(1);
    chk8({7'h00, toggle}, 8'h01);
    rd(8'h14, 1, 8'h03);
    rd(8'h21, 3, 8'h00);
    wr(8'h14, 8'h00);
    rd(8'h14, 1, 8'h00);
    wr(8'h14, 8'h80);
    chk8({7'h00, toggle}, 8'h00);
    rd(8'h14, 1, 8'h00);
    note("single");
    wr(8'h15, 8'h80);
    pkt(1'b1, 1'b0, 2, 1'b1);
    pkt(1'b1, 1'b0, 3, 1'b1);
    wait_irq(3);
    rd(8'h14, 1, 8'h03);
    rd(8'h21, 2, 8'h00);
    wr(8'h14, 8'h00);
    rd(8'h14, 1, 8'h01);
    rd(8'h21, 3, 8'h00);
    wr(8'h14, 8'h10);
    rd(8'h14, 1, 8'h00);
    pkt(1'b1, 1'b0, 2, 1'b0);
    pkt(1'b1, 1'b0, 2, 1'b1);
    wait_irq(5);
    wr(8'h14, 8'h10);
    rd(8'h14, 1, 8'h01);
    rd(8'h21, 2, 8'h00);
    wr(8'h14, 8'h00);
    note("double");
    wr(8'h15, 8'h00);
    wr(8'h14, 8'h20);
    pkt(1'b1, 1'b0, 2, 1'b0);
    repeat (20) @(negedge clk);
    chk_n(stl_n, 1);
    chk_n(irq_n, 5);
    rd(8'h14, 1, 8'h60);
    wr(8'h14, 8'h00);
    note("stall");
    wr(8'h15, 8'h40);
    wr(8'h14, 8'h20);
    pkt(1'b1, 1'b1, 2, 1'b0);
    wait_irq(6);
    chk_n(stl_n, 1);
    rd(8'h14, 1, 8'h2B);
    pkt(1'b1, 1'b0, 1, 1'b0);
    repeat (20) @(negedge clk);
    rd(8'h14, 1, 8'h2F);
    wr(8'h14, 8'h00);
    rd(8'h14, 1, 8'h00);
    note("iso");
    wr(8'h15, 8'h00);
    wr(8'h0E, 8'h00);
    wr(8'h12, 8'h00);
    n = 1 + $urandom_range(63);
    pkt(1'b0, 1'b0, n, 1'b1);
    wait_irq(7);
    rd(8'h16, 1, 8'(n));
    rd(8'h20, n, 8'h00);
    wr(8'h14, 8'h00);
    wr(8'h12, 8'hE0);
    rd(8'h12, 1, 8'h20);
    pkt(1'b0, 1'b0, 2, 1'b0);
    repeat (20) @(negedge clk);
    chk_n(irq_n, 7);
    note("ep0");
    wr(8'h0E, 8'h01);
    wr(8'h12, 8'h20);
    fork
      pkt(1'b1, 1'b0, 8, 1'b1);
      fill(16);
    join
    chk8({7'h00, full_seen}, 8'h01);
    wait_irq(8);
    rd(8'h21, 8, 8'h00);
    host.fetch(16);
    repeat (2) @(negedge clk);
    note("buffer");
    end_of_test();
  end
endmodule

// file: dv/ufm_host.sv
`timescale 1ns/100ps
module ufm_host (
  // Clock.
  input  wire logic       i_sys_clk,
  // Receive stream into the block.
  output logic            o_rx_valid,
  output logic            o_rx_ep,
  output logic            o_rx_last,
  output logic            o_rx_err,
  output logic      [7:0] o_rx_data,
  input  wire logic       i_rx_ready,
  // Transmit fetch.
  output logic            o_tx_rd,
  output logic            o_tx_rewind
);
  logic [7:0] pkt [64];
  int         hang = 0;
  initial begin
    {o_rx_valid, o_rx_ep, o_rx_last, o_rx_err, o_rx_data} = 12'h0A5;
    {o_tx_rd, o_tx_rewind} = 2'b00;
  end
  // A random idle cycle between bytes gives the slow case. Released lines are inverted so
  // that a stale byte can never pass for a fresh one.
  task automatic send(input logic ep, input logic err, input int n);
    int w;
    for (int i = 0; i < n; i++) begin
      o_rx_valid = 1'b1;
      {o_rx_ep, o_rx_last, o_rx_err, o_rx_data} = {ep, i == n - 1, err, pkt[i]};
      w = 0;
      while (!i_rx_ready && w < 200) begin
        @(negedge i_sys_clk);
        w++;
      end
      hang += int'(w == 200);
      @(negedge i_sys_clk);
      if (i == n - 1 || $urandom_range(1) == 1) begin
        o_rx_valid = 1'b0;
        {o_rx_ep, o_rx_last, o_rx_err, o_rx_data} = ~{o_rx_ep, o_rx_last, o_rx_err, o_rx_data};
        if (i < n - 1) @(negedge i_sys_clk);
      end
    end
  endtask
  task automatic fetch(input int n);
    o_tx_rewind = 1'b1;
    @(negedge i_sys_clk);
    o_tx_rewind = 1'b0;
    repeat (n) begin
      o_tx_rd = 1'b1;
      @(negedge i_sys_clk);
    end
    o_tx_rd = 1'b0;
  endtask
endmodule

// file: hw/ufm_pkg.sv
package ufm_pkg;
  // Indirect register map.
  localparam logic [7:0] REG_INDEX    = 8'h0E;
  localparam logic [7:0] REG_IN_CSRH  = 8'h12;
  localparam logic [7:0] REG_OUT_CSRL = 8'h14;
  localparam logic [7:0] REG_OUT_CSRH = 8'h15;
  localparam logic [7:0] REG_EP0_CNT  = 8'h16;
  localparam logic [7:0] REG_FIFO_EP0 = 8'h20;
  localparam logic [7:0] REG_FIFO_EP1 = 8'h21;
  localparam logic [7:0] REG_RESET    = 8'h00;
  // Endpoint FIFO space layout.
  localparam int         FIFO_BYTES   = 256;
  localparam logic [7:0] EP0_BASE     = 8'h00;
  localparam logic [7:0] EP0_SIZE     = 8'h40;
  localparam logic [7:0] OUT1_BASE    = 8'h40;
  localparam logic [7:0] OUT1_SIZE    = 8'h80;
  localparam logic [7:0] IN1_BASE     = 8'hC0;
  localparam logic [7:0] IN1_SIZE     = 8'h40;
  // OUT control/status low byte fields.
  localparam int CSRL_CLR_TOGGLE = 7;
  localparam int CSRL_SENT_STALL = 6;
  localparam int CSRL_SEND_STALL = 5;
  localparam int CSRL_FLUSH      = 4;
  localparam int CSRL_DATA_ERR   = 3;
  localparam int CSRL_OVERRUN    = 2;
  localparam int CSRL_FULL       = 1;
  localparam int CSRL_PKT_READY  = 0;
  // IN high byte and OUT high byte fields.
  localparam int CSRH_DBUF       = 7;
  localparam int CSRH_ISO        = 6;
  localparam int CSRH_ENDPOINT_DIRECTION_SELECT     = 5;
  // Receive word carried through the staging FIFO.
  typedef struct packed {
    logic       ep;
    logic       last;
    logic       err;
    logic [7:0] data;
  } ufm_rx_word_type;
endpackage

// file: hw/ufm_stage_fifo.sv
`timescale 1ns/100ps
module ufm_stage_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset_n,
  // Fill side.
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side.
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;
  logic [AW:0]      nxt_wr_ptr;
  logic [AW:0]      nxt_rd_ptr;
  logic             in_ready_ff;
  logic             push;
  logic             pop;

  assign o_out_valid = wr_ptr_ff != rd_ptr_ff;
  // Ready is registered from the next pointers, so the fill side never sees a gated path.
  assign o_in_ready  = in_ready_ff;
  assign nxt_wr_ptr  = wr_ptr_ff + (AW+1)'(push);
  assign nxt_rd_ptr  = rd_ptr_ff + (AW+1)'(pop);
  assign o_out_data  = mem_q[rd_ptr_ff[AW-1:0]];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_q[wr_ptr_ff[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr_ff   <= '0;
      rd_ptr_ff   <= '0;
      in_ready_ff <= 1'b1;
    end else begin
      wr_ptr_ff   <= nxt_wr_ptr;
      rd_ptr_ff   <= nxt_rd_ptr;
      in_ready_ff <= (nxt_wr_ptr[AW] == nxt_rd_ptr[AW])
                     || (nxt_wr_ptr[AW-1:0] != nxt_rd_ptr[AW-1:0]);
    end
  end
endmodule

// file: hw/ufm_top.sv
`timescale 1ns/100ps
module ufm_top #(
  parameter int STAGE_DEPTH = 4
) (
  // Clock and reset.
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  // Firmware indirect address/data pair.
  input  wire logic       i_adr_we,
  input  wire logic       i_dat_we,
  input  wire logic       i_dat_re,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  // Receive stream from the serial engine.
  input  wire logic       i_rx_valid,
  input  wire logic       i_rx_ep,
  input  wire logic       i_rx_last,
  input  wire logic       i_rx_err,
  input  wire logic [7:0] i_rx_data,
  output logic            o_rx_ready,
  // Transmit byte port to the serial engine.
  input  wire logic       i_tx_rd,
  input  wire logic       i_tx_ep,
  input  wire logic       i_tx_rewind,
  output logic      [7:0] o_tx_data,
  // Handshake and event outputs.
  output logic            o_stall_hs,
  output logic            o_out_irq,
  output logic            o_data_toggle
);
  typedef enum logic [1:0] {RX_IDLE, RX_LOAD, RX_DROP} ufm_rx_state_type;

  logic [7:0]            mem_q [ufm_pkg::FIFO_BYTES];
  logic [7:0]            adr_ff;
  logic                  index_ff;
  logic [7:0]            in_csrh_ff [2];
  logic [7:0]            out_csrh_ff;
  logic [7:0]            rdata_ff;
  logic [7:0]            tx_data_ff;
  logic [7:0]            tx_ptr_ff;
  logic [7:0]            in_wptr_ff;
  logic [7:0]            rx_ptr_ff;
  logic [7:0]            rd_ptr_ff;
  logic [6:0]            ep0_cnt_ff;
  logic                  ep0_ready_ff;
  logic [1:0]            pkt_cnt_ff;
  logic                  wslot_ff;
  logic                  rslot_ff;
  logic                  send_stall_ff;
  logic                  sent_stall_ff;
  logic                  flush_ff;
  logic                  data_err_ff;
  logic                  overrun_ff;
  logic                  toggle_ff;
  logic                  stall_hs_ff;
  logic                  irq_ff;
  ufm_rx_state_type      rx_state_ff;
  ufm_pkg::ufm_rx_word_type rx_in;
  ufm_pkg::ufm_rx_word_type rx_word;
  logic                  rx_valid;
  logic                  rx_take;
  logic                  fifo_access;
  logic                  csrl_wr;
  logic                  out_dbuf;
  logic                  out_iso;
  logic                  in_dbuf;
  logic                  out_full;
  logic                  sw_clr_ready;
  logic                  pop;
  logic                  hdr_accept;
  logic                  loading;
  logic                  commit;
  logic                  commit1;
  logic                  overrun_set;
  logic                  stall_now;
  logic [7:0]            out_max;
  logic [7:0]            rx_addr;
  logic [7:0]            fw_addr;

  // Base address of one OUT packet slot; a double-buffered slot is half the region.
  function automatic logic [7:0] out_slot_base(input logic dbuf, input logic slot);
    out_slot_base = ufm_pkg::OUT1_BASE;
    if (dbuf && slot) begin
      out_slot_base = ufm_pkg::OUT1_BASE + (ufm_pkg::OUT1_SIZE >> 1);
    end
  endfunction

  // Largest packet a region takes, halved when double buffered.
  function automatic logic [7:0] max_size(input logic dbuf, input logic [7:0] size);
    max_size = dbuf ? (size >> 1) : size;
  endfunction

  assign rx_in       = '{ep: i_rx_ep, last: i_rx_last, err: i_rx_err, data: i_rx_data};
  assign out_dbuf    = out_csrh_ff[ufm_pkg::CSRH_DBUF];
  assign in_dbuf     = in_csrh_ff[1][ufm_pkg::CSRH_DBUF];
  assign out_iso     = out_csrh_ff[ufm_pkg::CSRH_ISO];
  assign out_max     = max_size(out_dbuf, ufm_pkg::OUT1_SIZE);
  assign out_full    = out_dbuf ? (pkt_cnt_ff == 2'h2) : (pkt_cnt_ff != 2'h0);
  assign fifo_access = (i_dat_we || i_dat_re)
                       && (adr_ff == ufm_pkg::REG_FIFO_EP0 || adr_ff == ufm_pkg::REG_FIFO_EP1);
  // The memory has one write port, so the drain yields to firmware FIFO access.
  assign rx_take     = rx_valid && !fifo_access;
  assign csrl_wr     = i_dat_we && adr_ff == ufm_pkg::REG_OUT_CSRL;
  // A flush write releases its packet only through the flush path, never twice.
  assign sw_clr_ready = csrl_wr && index_ff && !i_wdata[ufm_pkg::CSRL_PKT_READY]
                        && !i_wdata[ufm_pkg::CSRL_FLUSH] && pkt_cnt_ff != 2'h0;
  assign pop         = (sw_clr_ready || flush_ff) && pkt_cnt_ff != 2'h0;
  assign stall_now   = rx_word.ep && send_stall_ff && !out_iso;
  assign overrun_set = rx_take && rx_state_ff == RX_IDLE && rx_word.ep && !stall_now
                       && out_full && out_iso;

  // The first byte decides whether the whole packet is stored.
  assign hdr_accept  = rx_word.ep ? (!stall_now && !out_full)
                       : (!in_csrh_ff[0][ufm_pkg::CSRH_ENDPOINT_DIRECTION_SELECT] && !ep0_ready_ff);

  assign loading = rx_take && (rx_state_ff == RX_LOAD || (rx_state_ff == RX_IDLE && hdr_accept));
  assign commit  = loading && rx_word.last && (!rx_word.err || (rx_word.ep && out_iso));
  assign commit1 = commit && rx_word.ep;
  assign rx_addr = rx_word.ep ? out_slot_base(out_dbuf, wslot_ff) + rx_ptr_ff
                              : ufm_pkg::EP0_BASE + rx_ptr_ff;
  assign fw_addr = (adr_ff == ufm_pkg::REG_FIFO_EP0) ? ufm_pkg::EP0_BASE + rd_ptr_ff
                   : (in_csrh_ff[1][ufm_pkg::CSRH_ENDPOINT_DIRECTION_SELECT] && i_dat_we)
                     ? ufm_pkg::IN1_BASE + in_wptr_ff
                     : out_slot_base(out_dbuf, rslot_ff) + rd_ptr_ff;

  ufm_stage_fifo #(
    .WIDTH ($bits(ufm_pkg::ufm_rx_word_type)),
    .DEPTH (STAGE_DEPTH)
  ) u_stage (
    .i_sys_clk   (i_sys_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (i_rx_valid),
    .i_in_data   (rx_in),
    .o_in_ready  (o_rx_ready),
    .o_out_valid (rx_valid),
    .o_out_data  (rx_word),
    .i_out_ready (!fifo_access)
  );

  // Receive state machine.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_state_ff <= RX_IDLE;
      rx_ptr_ff   <= ufm_pkg::REG_RESET;
    end else if (rx_take) begin
      unique case (rx_state_ff)
        RX_IDLE: rx_state_ff <= rx_word.last ? RX_IDLE : (hdr_accept ? RX_LOAD : RX_DROP);
        RX_LOAD: rx_state_ff <= rx_word.last ? RX_IDLE : RX_LOAD;
        RX_DROP: rx_state_ff <= rx_word.last ? RX_IDLE : RX_DROP;
      endcase
      if (rx_word.last) begin
        rx_ptr_ff <= ufm_pkg::REG_RESET;
      end else if (loading && rx_ptr_ff < (rx_word.ep ? out_max : ufm_pkg::EP0_SIZE) - 8'h01) begin
        rx_ptr_ff <= rx_ptr_ff + 8'h01;
      end
    end
  end

  // Shared memory write port; the two read ports are in the read data block below.
  always_ff @(posedge i_sys_clk) begin
    if (loading) begin
      mem_q[rx_addr] <= rx_word.data;
    end else if (i_dat_we && fifo_access) begin
      mem_q[fw_addr] <= i_wdata;
    end
  end

  // Endpoint1 OUT packet queue.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pkt_cnt_ff <= 2'h0;
      wslot_ff   <= 1'b0;
      rslot_ff   <= 1'b0;
    end else begin
      pkt_cnt_ff <= pkt_cnt_ff + {1'b0, commit1} - {1'b0, pop};
      if (commit1) begin
        wslot_ff <= out_dbuf ? !wslot_ff : 1'b0;
      end
      if (pop) begin
        rslot_ff <= out_dbuf ? !rslot_ff : 1'b0;
      end
    end
  end

  // Endpoint0 receive state.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ep0_ready_ff <= 1'b0;
      ep0_cnt_ff   <= 7'h00;
    end else if (commit && !rx_word.ep) begin
      ep0_ready_ff <= 1'b1;
      ep0_cnt_ff   <= rx_ptr_ff[6:0] + 7'h01;
    end else if (csrl_wr && !index_ff && !i_wdata[ufm_pkg::CSRL_PKT_READY]) begin
      ep0_ready_ff <= 1'b0;
    end
  end

  // OUT status flags; hardware sets win over software clears, but a clear-toggle write wins over a commit toggle.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      send_stall_ff <= 1'b0;
      sent_stall_ff <= 1'b0;
      flush_ff      <= 1'b0;
      data_err_ff   <= 1'b0;
      overrun_ff    <= 1'b0;
      toggle_ff     <= 1'b0;
      stall_hs_ff   <= 1'b0;
      irq_ff        <= 1'b0;
    end else begin
      stall_hs_ff <= rx_take && rx_state_ff == RX_IDLE && stall_now;
      irq_ff      <= commit;
      flush_ff    <= csrl_wr && index_ff && i_wdata[ufm_pkg::CSRL_FLUSH];
      if (csrl_wr && index_ff) begin
        send_stall_ff <= i_wdata[ufm_pkg::CSRL_SEND_STALL];
      end
      if (stall_hs_ff) begin
        sent_stall_ff <= 1'b1;
      end else if (csrl_wr && index_ff && !i_wdata[ufm_pkg::CSRL_SENT_STALL]) begin
        sent_stall_ff <= 1'b0;
      end
      if (overrun_set) begin
        overrun_ff <= 1'b1;
      end else if (csrl_wr && index_ff && !i_wdata[ufm_pkg::CSRL_OVERRUN]) begin
        overrun_ff <= 1'b0;
      end
      if (commit1 && rx_word.err && out_iso) begin
        data_err_ff <= 1'b1;
      end else if (pop) begin
        data_err_ff <= 1'b0;
      end
      if (csrl_wr && index_ff && i_wdata[ufm_pkg::CSRL_CLR_TOGGLE]) begin
        toggle_ff <= 1'b0;
      end else if (commit1) begin
        toggle_ff <= !toggle_ff;
      end
    end
  end

  // Indirect address, index and configuration registers.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      adr_ff        <= ufm_pkg::REG_RESET;
      index_ff      <= 1'b0;
      in_csrh_ff[0] <= ufm_pkg::REG_RESET;
      in_csrh_ff[1] <= ufm_pkg::REG_RESET;
      out_csrh_ff   <= ufm_pkg::REG_RESET;
    end else begin
      if (i_adr_we) begin
        adr_ff <= i_wdata;
      end
      if (i_dat_we && adr_ff == ufm_pkg::REG_INDEX) begin
        index_ff <= i_wdata[0];
      end
      if (i_dat_we && adr_ff == ufm_pkg::REG_IN_CSRH) begin
        // Endpoint0 keeps only its direction bit; it cannot double buffer.
        in_csrh_ff[index_ff] <= index_ff ? i_wdata
                                         : (i_wdata & (8'h01 << ufm_pkg::CSRH_ENDPOINT_DIRECTION_SELECT));
      end
      if (i_dat_we && adr_ff == ufm_pkg::REG_OUT_CSRH && index_ff) begin
        out_csrh_ff <= i_wdata;
      end
    end
  end

  // Firmware FIFO pointers.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_ptr_ff  <= ufm_pkg::REG_RESET;
      in_wptr_ff <= ufm_pkg::REG_RESET;
    end else begin
      if (pop || (csrl_wr && !index_ff)) begin
        rd_ptr_ff <= ufm_pkg::REG_RESET;
      end else if (i_dat_re && fifo_access) begin
        rd_ptr_ff <= rd_ptr_ff + 8'h01;
      end
      if (i_tx_rewind) begin
        in_wptr_ff <= ufm_pkg::REG_RESET;
      end else if (i_dat_we && adr_ff == ufm_pkg::REG_FIFO_EP1
                   && in_wptr_ff < max_size(in_dbuf, ufm_pkg::IN1_SIZE) - 8'h01) begin
        in_wptr_ff <= in_wptr_ff + 8'h01;
      end
    end
  end

  // Register read data and transmit byte port.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_ff   <= ufm_pkg::REG_RESET;
      tx_data_ff <= ufm_pkg::REG_RESET;
      tx_ptr_ff  <= ufm_pkg::REG_RESET;
    end else begin
      if (i_dat_re) begin
        unique case (adr_ff)
          ufm_pkg::REG_INDEX:    rdata_ff <= {7'h00, index_ff};
          ufm_pkg::REG_IN_CSRH:  rdata_ff <= in_csrh_ff[index_ff];
          ufm_pkg::REG_OUT_CSRH: rdata_ff <= out_csrh_ff;
          ufm_pkg::REG_EP0_CNT:  rdata_ff <= {1'b0, ep0_cnt_ff};
          ufm_pkg::REG_OUT_CSRL: rdata_ff <= index_ff
            ? {1'b0, sent_stall_ff, send_stall_ff, flush_ff, data_err_ff,
               overrun_ff, out_full, pkt_cnt_ff != 2'h0}
            : {7'h00, ep0_ready_ff};
          ufm_pkg::REG_FIFO_EP0,
          ufm_pkg::REG_FIFO_EP1: rdata_ff <= mem_q[fw_addr];
          default:               rdata_ff <= ufm_pkg::REG_RESET;
        endcase
      end
      if (i_tx_rewind) begin
        tx_ptr_ff <= ufm_pkg::REG_RESET;
      end else if (i_tx_rd) begin
        tx_data_ff <= mem_q[(i_tx_ep ? ufm_pkg::IN1_BASE : ufm_pkg::EP0_BASE) + tx_ptr_ff];
        tx_ptr_ff  <= tx_ptr_ff + 8'h01;
      end
    end
  end

  assign o_rdata       = rdata_ff;
  assign o_tx_data     = tx_data_ff;
  assign o_stall_hs    = stall_hs_ff;
  assign o_out_irq     = irq_ff;
  assign o_data_toggle = toggle_ff;

  sequence s_commit1;
    commit1 && !pop;
  endsequence
  sequence s_csrl_read;
    i_dat_re && adr_ff == ufm_pkg::REG_OUT_CSRL && !i_adr_we;
  endsequence

  property p_commit_irq;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      s_commit1 |=> o_out_irq && pkt_cnt_ff != 2'h0;
  endproperty
  property p_toggle_read;
    @(posedge i_sys_clk) disable iff (!i_reset_n) s_csrl_read |=> !o_rdata[7];
  endproperty

  commit_irq_a: assert property (p_commit_irq) else $error("Packet commit without irq.");
  toggle_read_a: assert property (p_toggle_read) else $error("Clear-toggle read as one.");
  count_top_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    i_dat_re && adr_ff == ufm_pkg::REG_EP0_CNT |=> !o_rdata[7]) else $error("Count bit 7 set.");
  stall_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    o_stall_hs |=> sent_stall_ff) else $error("Stall sent without flag.");
  stall_iso_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    o_stall_hs |-> !$past(out_iso)) else $error("Stall sent in iso mode.");
  flush_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    flush_ff && pkt_cnt_ff == 2'h1 && !commit1 |=> !flush_ff && pkt_cnt_ff == 2'h0)
    else $error("Flush did not drop packet.");
  overrun_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    overrun_ff && !csrl_wr |=> overrun_ff) else $error("Overrun cleared by itself.");
  full_single_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    s_commit1 ##0 !out_dbuf |=> out_full) else $error("Single-buffer full not shown.");
  dbuf_full_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    out_dbuf && pkt_cnt_ff == 2'h1 |-> !out_full) else $error("Double buffer full at one.");
  err_iso_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    $rose(data_err_ff) |-> $past(out_iso)) else $error("Data error outside iso mode.");
endmodule
